// ### rtl/fss_defines.svh
// offsets, field positions, reset values and counts of the state mover
`ifndef FSS_DEFINES_SVH
`define FSS_DEFINES_SVH
// avalon register word addresses
`define FSS_REG_CTRL 2'h0
`define FSS_REG_BASE 2'h1
`define FSS_REG_STATUS 2'h2
`define FSS_REG_COUNT 2'h3
// control register fields
`define FSS_CTRL_START 0
`define FSS_CTRL_OP_LSB 1
`define FSS_CTRL_OP_MSB 3
`define FSS_CTRL_OPSZ32 4
`define FSS_CTRL_LONG 5
// status register fields
`define FSS_STAT_BUSY 0
`define FSS_STAT_DONE 1
`define FSS_STAT_EXC_WAIT 2
`define FSS_STAT_OP_LSB 4
// reset values
`define FSS_BASE_RST 32'h0000_0000
`define FSS_CTRL_RST 6'h00
// status word fields
`define FSS_SW_ES 7
`define FSS_SW_TOP_LSB 11
// image geometry, in 32-bit words except the data area, in bytes
`define FSS_ENV_WORDS 7'd7
`define FSS_DATA_BYTES 80
`define FSS_FULL_WORDS 7'd27
`define FSS_EXT_ST_BASE 7'd8
`define FSS_EXT_XMM_BASE 7'd40
`define FSS_EXT_WORDS 7'd72
`endif

// ### rtl/fss_pkg.sv
// types shared by the floating-point state mover
package fss_pkg;
  typedef enum logic [2:0] {
    FSS_OP_CHECKED_FULL_STATE_STORE,
    FSS_OP_UNCHECKED_FULL_STATE_STORE,
    FSS_OP_FULL_STATE_RELOAD,
    FSS_OP_ENVIRONMENT_RELOAD,
    FSS_OP_ENVIRONMENT_RELOAD_ALT,
    FSS_OP_ENVIRONMENT_STORE,
    FSS_OP_EXTENDED_STATE_STORE,
    FSS_OP_EXTENDED_STATE_RELOAD
  } fss_op_t;

  typedef enum {
    FSS_IDLE,
    FSS_EXC_WAIT,
    FSS_ISSUE,
    FSS_WAIT_ACK,
    FSS_FINISH
  } fss_state_t;

  // architectural state as presented by the register stack
  typedef struct packed {
    logic [15:0] float_control_word;
    logic [15:0] float_status_word;
    logic [15:0] float_tag_word;
    logic [63:0] instr_pointer_64;
    logic [15:0] code_selector;
    logic [63:0] data_pointer_64;
    logic [15:0] data_selector;
    logic [7:0] opcode_byte1;
    logic [7:0] opcode_byte2;
    logic [31:0] media_csr;
    logic [7:0][79:0] float_physical_data_regs;
    logic [7:0][127:0] media128_regs;
  } fss_arch_t;

  // one word of the memory image
  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } fss_mem_t;

  // one reloaded image word handed back to the register stack
  typedef struct packed {
    logic valid;
    fss_op_t op;
    logic [6:0] index;
    logic [31:0] data;
  } fss_wb_t;
endpackage

// ### rtl/fss_state_mover.sv
// floating-point and media state save/restore engine with avalon slave
// What this block does
// - checked full store services pending unmasked exception before writing
// - unchecked full store writes state ignoring pending exceptions
// - full store writes eight data registers plus whole environment
// - after any full store all register tags become empty
// - data registers fill the 80 bytes right after the environment
// - data registers are written in stack order from stack top
// - control, status, tag words sit low in words at +00, +04, +08
// - full store and reload also carry the aliased 64-bit media registers
// - full store and reload never touch the 128-bit media state
// - environment store and reload move only environment fields
// - environment store keeps only truncated pointer forms
// - environment image equals leading environment part of full image
// - extended store and reload move 128-bit, 64-bit and float state
// - extended ops move pointers and opcode only when summary flag set
// - extended store leaves the tag word unchanged
// - extended store does not check pending exceptions
// - 64-bit mode with 32-bit operands stores selector plus offset pointers
// - saved opcode is low three bits of byte one then byte two
// - 64-bit media views are the low 64 bits of the 80-bit registers
`timescale 1ns/1ps
`include "fss_defines.svh"

module fss_state_mover #(
  parameter logic [31:0] MEDIA_CSR_MASK = 32'h0000ffff
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire fss_pkg::fss_arch_t arch,
  input wire logic exc_pending,
  input wire logic exc_serviced,
  output logic exc_service_req,
  output fss_pkg::fss_mem_t mem,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output fss_pkg::fss_wb_t wb,
  output logic tag_clear
);
  import fss_pkg::*;

  fss_state_t state;
  fss_op_t op;
  logic [31:0] base;
  logic opsz32;
  logic long_mode;
  logic done;
  logic [6:0] idx;
  logic [6:0] last;
  logic [6:0] count;
  logic es_now;
  logic [639:0] stack_image;
  logic [7:0] abridged_tag;
  logic [2:0] top;
  logic word_skip;
  logic [31:0] word_data;
  logic [6:0] rel;
  logic [9:0] bit_off;
  logic sel_off_ptrs;
  logic [10:0] opcode11;
  logic is_reload;
  logic av_take;
  logic start_req;
  fss_op_t start_op;

  // stack pointer of the live status word; it picks which physical
  // register is the stack top, so the image order follows the stack
  assign top = arch.float_status_word[`FSS_SW_TOP_LSB +: 3];
  // low three bits of byte one, then all of byte two
  assign opcode11 = {arch.opcode_byte1[2:0], arch.opcode_byte2};
  // a bus cycle counts only on the edge at which waitrequest is low, so a
  // start is honoured once even though the master holds write for two
  assign av_take = !avs_waitrequest && (avs_read || avs_write);
  assign start_req = av_take && avs_write
                     && avs_address == `FSS_REG_CTRL
                     && avs_writedata[`FSS_CTRL_START];
  assign start_op =
    fss_op_t'(avs_writedata[`FSS_CTRL_OP_MSB:`FSS_CTRL_OP_LSB]);
  // reloads read the image and hand words back; all other ops write it
  assign is_reload = op == FSS_OP_FULL_STATE_RELOAD
                     || op == FSS_OP_ENVIRONMENT_RELOAD
                     || op == FSS_OP_ENVIRONMENT_RELOAD_ALT
                     || op == FSS_OP_EXTENDED_STATE_RELOAD;
  // pointers as selector plus offset unless long mode with 64-bit operands
  assign sel_off_ptrs = !long_mode || opsz32;

  // registers rotated into stack order; the media view is the low 64 bits
  // of the same storage, so moving 80 bits carries both at once
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_stack
      localparam logic [2:0] SLOT = 3'(gi);
      assign stack_image[80*gi +: 80] =
        arch.float_physical_data_regs[top + SLOT];
      assign abridged_tag[gi] =
        arch.float_tag_word[2*gi +: 2] != 2'b11;
    end
  endgenerate

  // image word for the current index: data plus a skip flag
  // legacy image: 7 environment words then 20 words of stack data;
  // extended image: 8 environment words, 32 stack words, 32 media words
  always_comb begin
    word_skip = 1'b0;
    word_data = 32'h0000_0000;
    rel = 7'h00;
    bit_off = 10'h000;
    unique case (op)
      FSS_OP_EXTENDED_STATE_STORE, FSS_OP_EXTENDED_STATE_RELOAD: begin
        if (idx >= `FSS_EXT_XMM_BASE) begin
          rel = idx - `FSS_EXT_XMM_BASE;
          word_data = arch.media128_regs[rel[4:2]][32*rel[1:0] +: 32];
        end else if (idx >= `FSS_EXT_ST_BASE) begin
          rel = idx - `FSS_EXT_ST_BASE;
          bit_off = 10'(rel[4:2]) * 10'd80 + {5'h00, rel[1:0], 3'h0} * 10'd4;
          unique case (rel[1:0])
            2'd0, 2'd1: word_data = stack_image[bit_off +: 32];
            2'd2: word_data = {16'h0000, stack_image[bit_off +: 16]};
            default: word_data = 32'h0000_0000;
          endcase
        end else begin
          unique case (idx[2:0])
            3'd0: word_data = {arch.float_status_word,
                               arch.float_control_word};
            3'd1: word_data = {5'h00, es_now ? opcode11 : 11'h000,
                               8'h00, abridged_tag};
            3'd2: word_data = arch.instr_pointer_64[31:0];
            3'd3: word_data = sel_off_ptrs ? {16'h0000, arch.code_selector}
                                           : arch.instr_pointer_64[63:32];
            3'd4: word_data = arch.data_pointer_64[31:0];
            3'd5: word_data = sel_off_ptrs ? {16'h0000, arch.data_selector}
                                           : arch.data_pointer_64[63:32];
            3'd6: word_data = arch.media_csr;
            default: word_data = MEDIA_CSR_MASK;
          endcase
          // pointer words are passed over when no exception is summarised
          word_skip = idx >= 7'd2 && idx <= 7'd5 && !es_now;
        end
      end
      default: begin
        // legacy 32-bit image; the environment ops stop after word 6
        if (idx >= `FSS_ENV_WORDS) begin
          rel = idx - `FSS_ENV_WORDS;
          bit_off = {rel[4:0], 5'h00};
          word_data = stack_image[bit_off +: 32];
        end else begin
          unique case (idx[2:0])
            3'd0: word_data = {16'h0000, arch.float_control_word};
            3'd1: word_data = {16'h0000, arch.float_status_word};
            3'd2: word_data = {16'h0000, arch.float_tag_word};
            3'd3: word_data = arch.instr_pointer_64[31:0];
            3'd4: word_data = {5'h00, opcode11, arch.code_selector};
            3'd5: word_data = arch.data_pointer_64[31:0];
            default: word_data = {16'h0000, arch.data_selector};
          endcase
        end
      end
    endcase
  end

  // avalon waitrequest: one wait cycle, then the request is taken; the
  // wait cycle lets read data come from a flop, at the cost of a cycle
  always_ff @(posedge clock) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
    end else if (ce) begin
      if (avs_waitrequest && (avs_read || avs_write)) begin
        avs_waitrequest <= 1'b0;
      end else begin
        avs_waitrequest <= 1'b1;
      end
    end
  end

  // read data is prepared during the wait cycle; address 3 reads the word count
  always_ff @(posedge clock) begin
    if (!resetn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (ce && avs_waitrequest && avs_read) begin
      unique case (avs_address)
        `FSS_REG_CTRL: avs_readdata <= {26'h0, long_mode, opsz32,
                                        3'(op), 1'b0};
        `FSS_REG_BASE: avs_readdata <= base;
        `FSS_REG_STATUS: avs_readdata <= {25'h0, 3'(op), 1'b0,
                                          state == FSS_EXC_WAIT, done,
                                          state != FSS_IDLE};
        default: avs_readdata <= {25'h0, count};
      endcase
    end
  end

  // configuration written by software; ignored while a transfer runs
  always_ff @(posedge clock) begin
    if (!resetn) begin
      base <= `FSS_BASE_RST;
      op <= FSS_OP_CHECKED_FULL_STATE_STORE;
      opsz32 <= 1'b0;
      long_mode <= 1'b0;
    end else if (ce && av_take && avs_write && state == FSS_IDLE) begin
      if (avs_address == `FSS_REG_BASE) begin
        base <= avs_writedata;
      end
      if (avs_address == `FSS_REG_CTRL) begin
        op <= start_op;
        opsz32 <= avs_writedata[`FSS_CTRL_OPSZ32];
        long_mode <= avs_writedata[`FSS_CTRL_LONG];
      end
    end
  end

  // transfer sequencer; a finish cycle lets done and the tag pulse rise
  // together, so software never sees done before the tags are emptied
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state <= FSS_IDLE;
      idx <= 7'h00;
      last <= 7'h00;
      count <= 7'h00;
      done <= 1'b0;
    end else if (ce) begin
      unique case (state)
        FSS_IDLE: begin
          if (start_req) begin
            done <= 1'b0;
            idx <= 7'h00;
            count <= 7'h00;
            unique case (start_op)
              FSS_OP_ENVIRONMENT_RELOAD, FSS_OP_ENVIRONMENT_RELOAD_ALT,
              FSS_OP_ENVIRONMENT_STORE: last <= `FSS_ENV_WORDS - 7'd1;
              FSS_OP_EXTENDED_STATE_STORE, FSS_OP_EXTENDED_STATE_RELOAD:
                last <= `FSS_EXT_WORDS - 7'd1;
              default: last <= `FSS_FULL_WORDS - 7'd1;
            endcase
            // only the checked store stops for a pending exception
            if (start_op == FSS_OP_CHECKED_FULL_STATE_STORE
                && exc_pending) begin
              state <= FSS_EXC_WAIT;
            end else begin
              state <= FSS_ISSUE;
            end
          end
        end
        FSS_EXC_WAIT: begin
          if (exc_serviced) begin
            state <= FSS_ISSUE;
          end
        end
        FSS_ISSUE: begin
          if (word_skip) begin
            idx <= idx + 7'd1;
            state <= idx == last ? FSS_FINISH : FSS_ISSUE;
          end else begin
            state <= FSS_WAIT_ACK;
          end
        end
        FSS_WAIT_ACK: begin
          if (mem_ack) begin
            idx <= idx + 7'd1;
            count <= count + 7'd1;
            state <= idx == last ? FSS_FINISH : FSS_ISSUE;
          end
        end
        default: begin
          done <= 1'b1;
          state <= FSS_IDLE;
        end
      endcase
    end
  end

  // summary flag: live status word on store, image word 0 on reload;
  // on reload the live word is stale, since the image is about to replace it
  always_ff @(posedge clock) begin
    if (!resetn) begin
      es_now <= 1'b0;
    end else if (ce) begin
      if (state == FSS_IDLE && start_req) begin
        es_now <= arch.float_status_word[`FSS_SW_ES];
      end else if (state == FSS_WAIT_ACK && mem_ack && is_reload
                   && idx == 7'h00) begin
        es_now <= mem_rdata[16 + `FSS_SW_ES];
      end
    end
  end

  // memory request held from issue until acknowledged; base writes are
  // refused while busy, so the address cannot jump in mid-transfer
  always_ff @(posedge clock) begin
    if (!resetn) begin
      mem <= '0;
    end else if (ce) begin
      if (state == FSS_ISSUE && !word_skip) begin
        mem.req <= 1'b1;
        mem.we <= !is_reload;
        mem.addr <= base + {25'h0, idx};
        mem.wdata <= is_reload ? 32'h0000_0000 : word_data;
      end else if (state == FSS_WAIT_ACK && mem_ack) begin
        mem <= '0;
      end
    end
  end

  // reloaded words go back to the register stack one at a time; the stack
  // decodes them by op and index, so no image decoding is repeated here
  always_ff @(posedge clock) begin
    if (!resetn) begin
      wb <= '0;
    end else if (ce) begin
      wb.valid <= state == FSS_WAIT_ACK && mem_ack && is_reload;
      if (state == FSS_WAIT_ACK && mem_ack) begin
        wb.op <= op;
        wb.index <= idx;
        wb.data <= mem_rdata;
      end
    end
  end

  // exception handshake and tag clear after a full store
  always_ff @(posedge clock) begin
    if (!resetn) begin
      exc_service_req <= 1'b0;
      tag_clear <= 1'b0;
    end else if (ce) begin
      exc_service_req <= (state == FSS_IDLE && start_req
                          && start_op == FSS_OP_CHECKED_FULL_STATE_STORE
                          && exc_pending)
                         || (state == FSS_EXC_WAIT && !exc_serviced);
      // extended store never clears tags; a run cut short by reset
      // leaves the tags untouched as well
      tag_clear <= state == FSS_FINISH
                   && (op == FSS_OP_CHECKED_FULL_STATE_STORE
                       || op == FSS_OP_UNCHECKED_FULL_STATE_STORE);
    end
  end
endmodule

// ### bench/fss_mem_model.sv
// memory image model on the far side of the state mover
`timescale 1ns/1ps
module fss_mem_model (
  input wire logic clock,
  input wire logic resetn,
  input wire fss_pkg::fss_mem_t mem,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  import fss_pkg::*;
  logic [31:0] img [logic [31:0]];
  logic [2:0] wait_cnt;
  // answer after 1..4 cycles picked by address; unwritten words read a
  // pattern, and the data line toggles in every cycle with no request waiting
  always @(posedge clock) begin
    if (!resetn) begin
      wait_cnt <= 3'h0;
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0;
    end else if (mem.req && !mem_ack) begin
      if (wait_cnt == {1'b0, mem.addr[1:0]}) begin
        mem_ack <= 1'b1;
        wait_cnt <= 3'h0;
        if (mem.we) img[mem.addr] = mem.wdata;
        mem_rdata <= img.exists(mem.addr) ? img[mem.addr] :
          {mem.addr[15:0], ~mem.addr[15:0]};
      end else wait_cnt <= wait_cnt + 3'h1;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// ### bench/fss_state_mover_asserts.sv
// port assertions for the state mover
`timescale 1ns/1ps
module fss_state_mover_asserts (
  input wire logic clock,
  input wire logic resetn,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic exc_service_req,
  input wire fss_pkg::fss_mem_t mem,
  input wire logic mem_ack,
  input wire fss_pkg::fss_wb_t wb,
  input wire logic tag_clear
);
  import fss_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // one image word completing
  sequence s_ack;
    mem.req && mem_ack;
  endsequence
  a_wait_answer: assert property ($rose(avs_read || avs_write) |=>
    !avs_waitrequest) else $error("bus request not answered");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_req_hold: assert property (mem.req && !mem_ack |=> mem.req &&
    $stable(mem.addr) && $stable(mem.we) && $stable(mem.wdata))
    else $error("memory request changed before ack");
  a_req_drop: assert property (s_ack |=> !mem.req)
    else $error("memory request held after ack");
  a_reload_wb: assert property (s_ack ##0 !mem.we |=> wb.valid)
    else $error("reloaded word not handed back");
  a_store_no_wb: assert property (s_ack ##0 mem.we |=> !wb.valid)
    else $error("write-back during a store");
  a_exc_first: assert property (exc_service_req |-> !mem.req)
    else $error("memory traffic before exception service");
  a_tag_pulse: assert property (tag_clear |=> !tag_clear)
    else $error("tag clear longer than one cycle");
  a_wb_range: assert property (wb.valid |-> wb.index < 7'd72)
    else $error("write-back index past image");
endmodule
bind fss_state_mover fss_state_mover_asserts i_fss_state_mover_asserts (
  .clock(clock), .resetn(resetn), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .exc_service_req(exc_service_req), .mem(mem), .mem_ack(mem_ack),
  .wb(wb), .tag_clear(tag_clear));

// ### bench/test_fss_state_mover.sv
// self-checking bench running every save and restore operation
`timescale 1ns/1ps
module test_fss_state_mover;
  import fss_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic [1:0] avs_address = 2'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, mem_rdata, cur_base, a;
  logic avs_waitrequest, exc_service_req, mem_ack, tag_clear;
  logic exc_pending = 1'b0;
  logic exc_serviced = 1'b0;
  fss_arch_t arch = '0;
  fss_mem_t mem;
  fss_wb_t wb;
  logic [31:0] img [int];
  logic [31:0] seed = 32'd79;
  int n_errors = 0, samples_checked = 0, cycles = 0;
  int n_mem, n_wb, n_tag, n_exc;
  int n_ops = 0, seen_ops = 0;
  logic [2:0] cur_op = 3'h0;

  fss_state_mover i_fss_state_mover (.clock(clock), .resetn(resetn),
    .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .arch(arch), .exc_pending(exc_pending), .exc_serviced(exc_serviced),
    .exc_service_req(exc_service_req), .mem(mem), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .wb(wb), .tag_clear(tag_clear));
  fss_mem_model i_fss_mem_model (.clock(clock), .resetn(resetn),
    .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  always #10 clock = ~clock;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_errors++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  task automatic test_done();
    $display("checks %0d, errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // bus cycles hold the request until waitrequest is seen low
  task automatic av_wr(input logic [1:0] ad, input logic [31:0] d);
    @(posedge clock);
    avs_write <= 1'b1;
    avs_address <= ad;
    avs_writedata <= d;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  task automatic av_rd(input logic [1:0] ad, output logic [31:0] d);
    @(posedge clock);
    avs_read <= 1'b1;
    avs_address <= ad;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  // a core that services any requested exception one cycle later
  always @(posedge clock) begin
    exc_serviced <= exc_service_req;
    seen_ops <= n_ops;
    if (exc_service_req) exc_pending <= 1'b0;
    else if (seen_ops != n_ops) exc_pending <= 1'b1;
  end

  // monitor of image traffic, write-backs, tag clears and hang limit
  always @(posedge clock) begin
    cycles++;
    if (mem.req === 1'b1 && mem_ack === 1'b1) begin
      n_mem++;
      if (mem.we) img[int'(mem.addr - cur_base)] = mem.wdata;
    end
    if (wb.valid === 1'b1) begin
      n_wb++;
      a = cur_base + 32'(wb.index);
      check(wb.data, {a[15:0], ~a[15:0]});
      check(32'(wb.op), 32'(cur_op));
    end
    if (tag_clear === 1'b1) n_tag++;
    if (exc_service_req === 1'b1) n_exc++;
    // the hang limit comes last so that nothing follows the finish
    if (cycles == 20000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic run_op(input int i);
    fss_arch_t v;
    logic [7:0][79:0] st;
    logic [2:0] op, t;
    logic [31:0] base, rd, nw;
    logic [10:0] opc;
    op = (i == 8) ? 3'h6 : i[2:0];
    for (int k = 0; k < 60; k++) begin
      seed = lfsr(seed);
      v[k*32+:32] = seed;
    end
    v.float_status_word[7] = (i == 8);
    t = v.float_status_word[13:11];
    st = v.float_physical_data_regs;
    opc = {v.opcode_byte1[2:0], v.opcode_byte2};
    base = {16'h0, i[3:0], 12'h000};
    // extended reload takes the summary flag from the pattern in word 0,
    // which is address bit 7 of the base
    nw = (op < 3'h3) ? 27 : (op < 3'h6) ? 7
         : ((op == 3'h7) ? base[7] : v.float_status_word[7]) ? 72 : 68;
    img.delete();
    {n_mem, n_wb, n_tag, n_exc} = '0;
    cur_base = base;
    cur_op = op;
    @(posedge clock);
    arch <= v;
    n_ops <= n_ops + 1;
    av_wr(2'h1, base);
    // the last run uses long mode with 32-bit operands
    av_wr(2'h0, {26'h0, (i == 8) ? 2'b11 : 2'b01, op, 1'b1});
    av_wr(2'h1, ~base);
    do av_rd(2'h2, rd); while (rd[1] !== 1'b1);
    av_rd(2'h1, rd);
    check(rd, base);
    av_rd(2'h3, rd);
    check(rd, nw);
    check(n_mem, nw);
    if (op == 3'h0) check(n_exc != 0, 1);
    if (op == 3'h1 || op == 3'h6) check(n_exc, 0);
    if (op == 3'h2 || op == 3'h3 || op == 3'h4 || op == 3'h7)
      check(n_wb, nw);
    if (op < 3'h2) begin
      check(n_tag, 1);
      check(img[0][15:0], v.float_control_word);
      check(img[1][15:0], v.float_status_word);
      check(img[2][15:0], v.float_tag_word);
      check(img[4][26:16], opc);
      check(img[7], st[t][31:0]);
      check(img[26], st[t + 3'd7][79:48]);
    end
    if (op == 3'h5) begin
      check(img[0][15:0], v.float_control_word);
      check(img[6][15:0], v.data_selector);
    end
    if (op == 3'h6) begin
      check(n_tag, 0);
      check(img[0], {v.float_status_word, v.float_control_word});
      check(img[40], v.media128_regs[0][31:0]);
      if (i == 8) begin
        check(img[1][26:16], opc);
        check(img[3], {16'h0, v.code_selector});
        check(img[5], {16'h0, v.data_selector});
      end else begin
        check(img.exists(2), 0);
      end
    end
    $display("test of operation %0d finished", op);
  endtask

  initial begin
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    for (int i = 0; i < 9; i++) run_op(i);
    test_done();
  end
endmodule
